// ===== mtrcs_pkg.sv
// Purpose: constants and types for the transmit/receive control and status block
// Assumes: one 25 MHz clock; tx and rx datapath events arrive on that clock
// Notes:
// Contract
// - transmit control bit 6 disables the 2048-byte jabber timer; clear keeps it active.
// - bit 5 clear abandons a frame after more than 15 collisions; set keeps retrying.
// - for index 2, bit 4 stops padding and bit 3 stops FCS appending.
// - for index 1, bit 2 stops padding and bit 1 stops FCS appending.
// - software sets bit 0 to send; the MAC clears it when sending completes.
// - two identical status registers, index 1 at 03H, index 2 at 04H; bits 1:0 zero.
// - status bit 7 set when the frame was cut after more than 2048 bytes.
// - status bit 6 set when carrier drops while sending; meaningless in loopback.
// - status bit 5 set when no carrier seen while sending; meaningless in loopback.
// - status bit 4 set for a collision after the first 64 bytes.
// - status bit 3 set for any collision during that frame.
// - status bit 2 set when the frame was abandoned after 16 collisions.
// - receive control bit 6 disables the 2048-byte receive watchdog; clear keeps it active.
// - receive control bit 5 discards received frames longer than 1522 bytes.
// - receive control bit 4 discards received frames with a bad FCS.
// - per-index sticky completion flags, cleared by read or by writing one.

package mtrcs_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_TX_CTL = 6'h02;
	localparam logic [5:0] IDX_TX_ST1 = 6'h03;
	localparam logic [5:0] IDX_TX_ST2 = 6'h04;
	localparam logic [5:0] IDX_RX_CTL = 6'h05;
	localparam logic [5:0] IDX_EVT = 6'h30;
	localparam logic [5:0] IDX_MASK = 6'h31;
	// transmit control fields
	localparam int TXC_JAB_OFF = 6;
	localparam int TXC_RETRY = 5;
	localparam int TXC_PAD2 = 4;
	localparam int TXC_FCS2 = 3;
	localparam int TXC_PAD1 = 2;
	localparam int TXC_FCS1 = 1;
	localparam int TXC_REQ = 0;
	// transmit status fields
	localparam int TXS_JAB = 7;
	localparam int TXS_CLOST = 6;
	localparam int TXS_NOCRS = 5;
	localparam int TXS_LATE = 4;
	localparam int TXS_COL = 3;
	localparam int TXS_EXC = 2;
	// receive control fields
	localparam int RXC_WD_OFF = 6;
	localparam int RXC_LONG = 5;
	localparam int RXC_BADFCS = 4;
	localparam int RXC_ALLMC = 3;
	localparam int RXC_RUNT = 2;
	localparam int RXC_PROMISC = 1;
	localparam int RXC_EN = 0;
	// reset values
	localparam logic [6:0] TXC_RST = 7'h00;
	localparam logic [7:0] TXS_RST = 8'h00;
	localparam logic [6:0] RXC_RST = 7'h00;
	localparam logic [1:0] EVT_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;
	// byte and collision counts
	localparam logic [11:0] JAB_BYTES = 12'h800;
	localparam logic [11:0] COL_WINDOW = 12'h040;
	localparam logic [4:0] COL_LAST = 5'h0F;
	localparam logic [11:0] RX_WD_BYTES = 12'h800;
	localparam logic [11:0] RX_LONG_BYTES = 12'h5F2;
	localparam logic [11:0] RX_RUNT_BYTES = 12'h040;
	localparam logic [11:0] CNT_MAX = 12'hFFF;
	localparam logic [4:0] COL_MAX = 5'h1F;

	typedef enum logic {TX_IDLE, TX_SEND} mtrcs_tx_state_t;

	typedef struct packed {
		logic byte_sent;
		logic frame_end;
		logic collision;
		logic carrier;
		logic loopback;
	} mtrcs_tx_ev_t;

	typedef struct packed {
		logic start;
		logic idx2;
		logic pad_en;
		logic fcs_en;
		logic retry;
		logic stop;
	} mtrcs_tx_cmd_t;

	typedef struct packed {
		logic sof;
		logic byte_in;
		logic eof;
		logic fcs_bad;
		logic addr_match;
		logic multicast;
	} mtrcs_rx_ev_t;

	typedef struct packed {
		logic accept;
		logic discard;
		logic wd_cut;
	} mtrcs_rx_res_t;

	typedef struct packed {
		mtrcs_tx_state_t tst;
		logic [6:0] txc;
		logic [1:0][7:0] txs;
		logic [6:0] rxc;
		logic [1:0] evt;
		logic [1:0] mask;
		logic [7:0] rdata;
		logic irq;
		logic idx2;
		logic [11:0] bcnt;
		logic [4:0] ncol;
		logic crs_seen;
		logic [7:0] work;
		mtrcs_tx_cmd_t cmd;
		logic ractive;
		logic rcut;
		logic [11:0] rcnt;
		mtrcs_rx_res_t rres;
		logic wait_r;
	} mtrcs_state_t;

	// everything zero except waitrequest, which idles high
	localparam mtrcs_state_t ST_RST = mtrcs_state_t'({{($bits(mtrcs_state_t)-1){1'b0}}, 1'b1});
endpackage : mtrcs_pkg

// ===== mtrcs_core.sv
// Purpose: transmit control, per-index transmit status and receive control of the MAC
// Assumes: datapath events are one-cycle pulses on clk, except carrier and loopback levels
// Notes: registers reached over Avalon-MM; every access answers after one wait cycle
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module mtrcs_core import mtrcs_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// avalon-mm slave
	input wire logic [7:0] av_address,
	input wire logic av_read,
	input wire logic av_write,
	input wire logic [31:0] av_writedata,
	input wire logic [3:0] av_byteenable,
	output logic [31:0] av_readdata,
	output logic av_waitrequest,
	// transmit datapath
	input wire mtrcs_tx_ev_t tx_ev,
	output mtrcs_tx_cmd_t tx_cmd,
	// receive datapath
	input wire mtrcs_rx_ev_t rx_ev,
	output mtrcs_rx_res_t rx_res,
	// interrupt
	output logic irq
);

	mtrcs_state_t q;
	mtrcs_state_t s;

	function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
		return (addr[1:0] == 2'h0) && (addr[7:2] == idx);
	endfunction : reg_hit

	logic rfire;
	logic wfire;
	logic wr_txc;
	logic jab_cut;
	logic col_now;
	logic fin;
	logic sw_req;
	logic rx_ok;
	logic [11:0] rx_len;

	assign rfire = av_read && !q.wait_r;
	assign wfire = av_write && !q.wait_r && av_byteenable[0];
	assign wr_txc = wfire && reg_hit(av_address, IDX_TX_CTL);
	assign sw_req = wr_txc && av_writedata[TXC_REQ];
	assign jab_cut = (q.tst == TX_SEND) && tx_ev.byte_sent && (q.bcnt == JAB_BYTES)
		&& !q.txc[TXC_JAB_OFF];
	assign col_now = (q.tst == TX_SEND) && tx_ev.collision && !jab_cut;
	assign rx_len = q.rcnt;

	always_comb begin
		s = q;
		s.cmd.start = 1'b0;
		s.cmd.retry = 1'b0;
		s.cmd.stop = 1'b0;
		s.rres = '0;
		fin = 1'b0;
		rx_ok = 1'b0;

		// bus handshake: one wait cycle, read data captured while waitrequest is high
		if ((av_read || av_write) && q.wait_r) begin
			s.wait_r = 1'b0;
			if (av_read) begin
				if (reg_hit(av_address, IDX_TX_CTL)) begin
					s.rdata = {1'b0, q.txc};
				end else if (reg_hit(av_address, IDX_TX_ST1)) begin
					s.rdata = q.txs[0];
				end else if (reg_hit(av_address, IDX_TX_ST2)) begin
					s.rdata = q.txs[1];
				end else if (reg_hit(av_address, IDX_RX_CTL)) begin
					s.rdata = {1'b0, q.rxc};
				end else if (reg_hit(av_address, IDX_EVT)) begin
					s.rdata = {6'h00, q.evt};
				end else if (reg_hit(av_address, IDX_MASK)) begin
					s.rdata = {6'h00, q.mask};
				end else begin
					s.rdata = 8'h00;
				end
			end
		end else begin
			s.wait_r = 1'b1;
		end

		// software writes first so that hardware events below win
		if (wr_txc) begin
			s.txc = av_writedata[6:0];
		end
		if (wfire && reg_hit(av_address, IDX_RX_CTL)) begin
			s.rxc = av_writedata[6:0];
		end
		if (wfire && reg_hit(av_address, IDX_MASK)) begin
			s.mask = av_writedata[1:0];
		end
		// only flags that were actually returned are cleared by the read
		if (rfire && reg_hit(av_address, IDX_EVT)) begin
			s.evt = s.evt & ~q.rdata[1:0];
		end
		if (wfire && reg_hit(av_address, IDX_EVT)) begin
			s.evt = s.evt & ~av_writedata[1:0];
		end

		// transmit sequencing
		case (q.tst)
			TX_IDLE: begin
				if (q.txc[TXC_REQ]) begin
					s.tst = TX_SEND;
					s.bcnt = 12'h000;
					s.ncol = 5'h00;
					s.crs_seen = 1'b0;
					s.work = 8'h00;
					s.cmd.start = 1'b1;
					s.cmd.idx2 = q.idx2;
					if (q.idx2) begin
						s.cmd.pad_en = !q.txc[TXC_PAD2];
						s.cmd.fcs_en = !q.txc[TXC_FCS2];
					end else begin
						s.cmd.pad_en = !q.txc[TXC_PAD1];
						s.cmd.fcs_en = !q.txc[TXC_FCS1];
					end
				end
			end
			TX_SEND: begin
				if (tx_ev.carrier) begin
					s.crs_seen = 1'b1;
				end else if (q.crs_seen && !tx_ev.loopback) begin
					s.work[TXS_CLOST] = 1'b1;
				end
				if (tx_ev.byte_sent && (q.bcnt != CNT_MAX)) begin
					s.bcnt = q.bcnt + 12'h001;
				end
				if (jab_cut) begin
					// byte beyond the limit: the datapath must drop the rest of the frame
					s.work[TXS_JAB] = 1'b1;
					s.cmd.stop = 1'b1;
					fin = 1'b1;
				end else if (col_now) begin
					s.work[TXS_COL] = 1'b1;
					if (q.bcnt >= COL_WINDOW) begin
						s.work[TXS_LATE] = 1'b1;
					end
					if (q.ncol != COL_MAX) begin
						s.ncol = q.ncol + 5'h01;
					end
					if ((q.ncol == COL_LAST) && !q.txc[TXC_RETRY]) begin
						s.work[TXS_EXC] = 1'b1;
						s.cmd.stop = 1'b1;
						fin = 1'b1;
					end else begin
						// backoff is the datapath's job; count restarts with the frame
						s.cmd.retry = 1'b1;
						s.bcnt = 12'h000;
					end
				end else if (tx_ev.frame_end) begin
					fin = 1'b1;
				end
				if (fin) begin
					if (!q.crs_seen && !tx_ev.carrier && !tx_ev.loopback) begin
						s.work[TXS_NOCRS] = 1'b1;
					end
					s.work[1:0] = 2'h0;
					s.txs[q.idx2] = s.work;
					s.evt[q.idx2] = 1'b1;
					s.idx2 = !q.idx2;
					s.tst = TX_IDLE;
					// a fresh request written in the same cycle survives
					if (!sw_req) begin
						s.txc[TXC_REQ] = 1'b0;
					end
				end
			end
			default: begin
				s.tst = TX_IDLE;
			end
		endcase

		// receive filtering
		if (rx_ev.sof) begin
			s.ractive = q.rxc[RXC_EN];
			s.rcnt = 12'h000;
			s.rcut = 1'b0;
		end else if (q.ractive && rx_ev.byte_in) begin
			if (q.rcnt != CNT_MAX) begin
				s.rcnt = q.rcnt + 12'h001;
			end
			if ((q.rcnt == RX_WD_BYTES) && !q.rxc[RXC_WD_OFF] && !q.rcut) begin
				s.rcut = 1'b1;
				s.rres.wd_cut = 1'b1;
			end
		end
		if (q.ractive && rx_ev.eof && !rx_ev.sof) begin
			rx_ok = q.rxc[RXC_EN]
				&& (rx_ev.addr_match || q.rxc[RXC_PROMISC]
					|| (rx_ev.multicast && q.rxc[RXC_ALLMC]))
				&& !((rx_len < RX_RUNT_BYTES) && !q.rxc[RXC_RUNT]);
			if (rx_ev.fcs_bad && q.rxc[RXC_BADFCS]) begin
				rx_ok = 1'b0;
			end
			if ((rx_len > RX_LONG_BYTES) && q.rxc[RXC_LONG]) begin
				rx_ok = 1'b0;
			end
			if (q.rcut) begin
				rx_ok = 1'b0;
			end
			s.rres.accept = rx_ok;
			s.rres.discard = !rx_ok;
			s.ractive = 1'b0;
		end

		s.irq = |(s.evt & s.mask);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= ST_RST;
		end else begin
			q <= s;
		end
	end

	assign av_readdata = {24'h000000, q.rdata};
	assign av_waitrequest = q.wait_r;
	assign tx_cmd = q.cmd;
	assign rx_res = q.rres;
	assign irq = q.irq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence sq_tx_launch;
		(q.tst == TX_IDLE) && q.txc[TXC_REQ] ##1 (q.tst == TX_SEND);
	endsequence

	sequence sq_jab_over;
		(q.tst == TX_SEND) && tx_ev.byte_sent && (q.bcnt == 12'h800) && !q.txc[TXC_JAB_OFF];
	endsequence

	chk_tx_launch: assert property (sq_tx_launch |-> tx_cmd.start && tx_cmd.idx2 == $past(q.idx2))
		else $error("frame launch without start pulse");

	chk_jab_cut: assert property (sq_jab_over |=> tx_cmd.stop && q.tst == TX_IDLE ##0
		q.txs[tx_cmd.idx2][7])
		else $error("jabber limit did not truncate the frame");

	chk_jab_off: assert property ((q.tst == TX_SEND) && q.txc[TXC_JAB_OFF] && !tx_ev.collision
		|=> !tx_cmd.stop)
		else $error("frame stopped while jabber timer disabled");

	chk_excess_abort: assert property ((q.tst == TX_SEND) && tx_ev.collision && !jab_cut
		&& (q.ncol == 5'h0F) && !q.txc[TXC_RETRY]
		|=> tx_cmd.stop && !tx_cmd.retry && q.evt[tx_cmd.idx2])
		else $error("sixteenth collision did not abort");

	chk_retry_keep: assert property ((q.tst == TX_SEND) && tx_ev.collision && !jab_cut
		&& q.txc[TXC_RETRY] |=> tx_cmd.retry && (q.tst == TX_SEND) && q.bcnt == 12'h000)
		else $error("retry mode did not retry");

	chk_pad_select: assert property (tx_cmd.start |-> tx_cmd.pad_en == !(tx_cmd.idx2 ?
		$past(q.txc[4]) : $past(q.txc[2])))
		else $error("pad enable taken from the wrong index");

	chk_status_rsvd: assert property ((q.txs[0][1:0] == 2'h0) && (q.txs[1][1:0] == 2'h0))
		else $error("reserved status bits not zero");

	chk_late_col: assert property (col_now && (q.bcnt > 12'h03F) |=> q.work[4] && q.work[3])
		else $error("late collision not flagged");

	chk_rx_wdog: assert property (q.ractive && rx_ev.byte_in && !rx_ev.sof && !q.rcut
		&& (q.rcnt == 12'h800) && !q.rxc[6] |=> rx_res.wd_cut ##1 !rx_res.wd_cut)
		else $error("receive watchdog did not fire once");

	chk_rx_long: assert property (q.ractive && rx_ev.eof && !rx_ev.sof && (q.rcnt > 12'h5F2)
		&& q.rxc[5] |=> rx_res.discard && !rx_res.accept)
		else $error("oversize frame accepted");

	chk_rx_enable: assert property (rx_res.accept |-> $past(q.rxc[0]) && $past(q.ractive))
		else $error("frame accepted while receive disabled");

	chk_irq_level: assert property (irq == |(q.evt & q.mask))
		else $error("interrupt disagrees with flags and mask");

	// normal end of frame: no collision or jabber cut competing in that cycle
	sequence sq_tx_done;
		(q.tst == TX_SEND) && tx_ev.frame_end && !tx_ev.collision && !jab_cut;
	endsequence

	chk_req_clear: assert property (sq_tx_done ##0 !sw_req
		|=> !q.txc[TXC_REQ] && (q.tst == TX_IDLE))
		else $error("send request not cleared at frame end");

	chk_loop_nocrs: assert property (sq_tx_done ##0 (tx_ev.loopback && !q.crs_seen)
		|=> !q.txs[tx_cmd.idx2][TXS_NOCRS])
		else $error("no-carrier flag set in loopback");

	chk_rx_badfcs: assert property (q.ractive && rx_ev.eof && !rx_ev.sof && rx_ev.fcs_bad
		&& q.rxc[RXC_BADFCS] |=> rx_res.discard && !rx_res.accept)
		else $error("frame with bad check sequence accepted");
endmodule : mtrcs_core

`default_nettype wire

// ===== mtrcs_phy_model.sv
// Purpose: PHY and medium stand-in for the MAC control and status block
// Assumes: events move one cycle at a time on the MAC clock
// Notes: released receive levels go to the inverse of the last value
`timescale 1ns/10ps
`default_nettype none

module mtrcs_phy_model import mtrcs_pkg::*; (
	// clock
	input wire logic clk,
	// mac side
	input wire mtrcs_tx_cmd_t tx_cmd,
	output mtrcs_tx_ev_t tx_ev,
	output mtrcs_rx_ev_t rx_ev
);
	initial begin
		tx_ev = '0;
		rx_ev = '0;
	end

	// bytes flow only after the start pulse; gap models a slow medium
	task automatic tx_frame(input int n, input int ncol, input bit crs, input bit drop, input int gap,
			input bit lb);
		int i;
		i = 0;
		while (tx_cmd.start !== 1'b1 && i < 64) begin
			@(posedge clk);
			i++;
		end
		repeat (gap) @(posedge clk);
		for (i = 0; i < n; i++) begin
			@(posedge clk);
			tx_ev.byte_sent <= 1'b1;
			tx_ev.loopback <= lb;
			tx_ev.carrier <= crs && !(drop && i == n - 1);
		end
		for (i = 0; i <= 2 * ncol; i++) begin
			@(posedge clk);
			tx_ev.byte_sent <= 1'b0;
			tx_ev.carrier <= crs && !drop;
			tx_ev.collision <= !i[0] && i < 2 * ncol;
			tx_ev.frame_end <= i == 2 * ncol;
		end
		@(posedge clk);
		tx_ev <= '0;
	endtask : tx_frame

	// eof stands in a cycle of its own, after the last byte
	task automatic rx_frame(input int n, input bit bad, input bit hit, input bit mc);
		@(posedge clk);
		rx_ev.sof <= 1'b1;
		repeat (n) begin
			@(posedge clk);
			rx_ev.sof <= 1'b0;
			rx_ev.byte_in <= 1'b1;
		end
		@(posedge clk);
		rx_ev <= {3'b001, bad, hit, mc};
		@(posedge clk);
		rx_ev <= {3'b000, !bad, !hit, !mc};
	endtask : rx_frame
endmodule : mtrcs_phy_model

`default_nettype wire

// ===== tb_mtrcs_core.sv
// Purpose: self-checking bench for the MAC transmit/receive control and status block
// Assumes: registers at four times their index, one wait cycle per access
// Notes: full-size frames, the block has no count parameters
`timescale 1ns/10ps
`default_nettype none

module tb_mtrcs_core import mtrcs_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] av_address = 8'h00;
	logic av_read = 1'b0;
	logic av_write = 1'b0;
	logic [31:0] av_writedata = 32'h0;
	logic [3:0] av_byteenable = 4'hF;
	logic [31:0] av_readdata;
	logic av_waitrequest;
	logic irq;
	mtrcs_tx_ev_t tx_ev;
	mtrcs_tx_cmd_t tx_cmd;
	mtrcs_tx_cmd_t cmd_seen;
	mtrcs_rx_ev_t rx_ev;
	mtrcs_rx_res_t rx_res;
	int n_acc = 0;
	int n_dis = 0;
	int n_wd = 0;
	int n_rt = 0;
	int n_sp = 0;
	bit lb_on = 1'b0;
	int err_count = 0;
	int n_tests = 0;
	logic [31:0] q;

	always #20 clk = ~clk;

	mtrcs_core mtrcs_core_i (.clk(clk), .rst_n(rst_n), .av_address(av_address),
		.av_read(av_read), .av_write(av_write), .av_writedata(av_writedata),
		.av_byteenable(av_byteenable), .av_readdata(av_readdata),
		.av_waitrequest(av_waitrequest), .tx_ev(tx_ev), .tx_cmd(tx_cmd), .rx_ev(rx_ev),
		.rx_res(rx_res), .irq(irq));
	mtrcs_phy_model mtrcs_phy_model_i (.clk(clk), .tx_cmd(tx_cmd), .tx_ev(tx_ev), .rx_ev(rx_ev));

	always @(posedge clk) begin
		if (tx_cmd.start === 1'b1) cmd_seen <= tx_cmd;
		if (rx_res.accept === 1'b1) n_acc <= n_acc + 1;
		if (rx_res.discard === 1'b1) n_dis <= n_dis + 1;
		if (rx_res.wd_cut === 1'b1) n_wd <= n_wd + 1;
		if (tx_cmd.retry === 1'b1) n_rt <= n_rt + 1;
		if (tx_cmd.stop === 1'b1) n_sp <= n_sp + 1;
	end

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// request held until waitrequest is sampled low
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk);
		av_address <= a;
		av_read <= !w;
		av_write <= w;
		av_writedata <= {24'h000000, d};
		@(posedge clk);
		while (av_waitrequest !== 1'b0 && k < 16) begin
			@(posedge clk);
			k++;
		end
		if (k >= 16) err_count++;
		q = av_readdata;
		av_read <= 1'b0;
		av_write <= 1'b0;
	endtask : bus

	task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] e);
		bus(a, 1'b0, 8'h00);
		chk(what, q, {24'h000000, e});
	endtask : rchk

	task automatic test_reset;
		logic [7:0] regs [6] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'hC0, 8'hC4};
		chk("irq", {31'h0, irq}, 32'h0);
		for (int i = 0; i < 6; i++) rchk("reset value", regs[i], 8'h00);
		rchk("misaligned", 8'h09, 8'h00);
		bus(8'h0C, 1'b1, 8'hFF);
		rchk("status read only", 8'h0C, 8'h00);
		bus(8'h08, 1'b1, 8'h7E);
		rchk("tx control", 8'h08, 8'h7E);
		$display("reset test done");
	endtask : test_reset

	task automatic tx_case(input logic [7:0] ctl, input int n, input int ncol, input bit crs,
			input bit drop, input logic [7:0] sa, input logic [7:0] se, input logic [2:0] ce);
		int r;
		int p;
		bus(8'h08, 1'b1, ctl);
		r = n_rt;
		p = n_sp;
		mtrcs_phy_model_i.tx_frame(n, ncol, crs, drop, ncol, lb_on);
		repeat (2) @(posedge clk);
		chk("stop pulses", n_sp - p, (se[7] || se[2]) ? 1 : 0);
		chk("retry pulses", n_rt - r, ncol - (se[2] ? 1 : 0));
		chk("frame setup", {29'h0, cmd_seen.idx2, cmd_seen.pad_en, cmd_seen.fcs_en}, {29'h0, ce});
		rchk("tx status", sa, se);
		rchk("request bit", 8'h08, ctl & 8'h7E);
	endtask : tx_case

	task automatic test_tx;
		tx_case(8'h07, 10, 1, 1, 0, 8'h0C, 8'h08, 3'b000);
		tx_case(8'h19, 3, 16, 0, 0, 8'h10, 8'h2C, 3'b100);
		tx_case(8'h21, 70, 16, 1, 1, 8'h0C, 8'h58, 3'b011);
		tx_case(8'h01, 2049, 0, 1, 0, 8'h10, 8'h80, 3'b111);
		tx_case(8'h41, 2049, 0, 1, 0, 8'h0C, 8'h00, 3'b011);
		lb_on = 1'b1;
		tx_case(8'h01, 10, 0, 0, 0, 8'h10, 8'h00, 3'b111);
		tx_case(8'h01, 10, 0, 1, 1, 8'h0C, 8'h00, 3'b011);
		lb_on = 1'b0;
		$display("tx test done");
	endtask : test_tx

	task automatic test_irq;
		chk("irq masked", {31'h0, irq}, 32'h0);
		bus(8'hC4, 1'b1, 8'h02);
		repeat (2) @(posedge clk);
		chk("irq", {31'h0, irq}, 32'h1);
		bus(8'hC0, 1'b1, 8'h02);
		rchk("flags", 8'hC0, 8'h01);
		rchk("flags read clear", 8'hC0, 8'h00);
		chk("irq clear", {31'h0, irq}, 32'h0);
		$display("irq test done");
	endtask : test_irq

	// a negative accept or discard expectation leaves that count unchecked; the watchdog count is always checked
	task automatic rx_case(input logic [7:0] rxc, input int n, input bit bad, input bit hit,
			input bit mc, input int ea, input int ed, input int ew);
		int a;
		int d;
		int w;
		bus(8'h14, 1'b1, rxc);
		a = n_acc;
		d = n_dis;
		w = n_wd;
		mtrcs_phy_model_i.rx_frame(n, bad, hit, mc);
		repeat (3) @(posedge clk);
		if (ea >= 0) chk("accepted", n_acc - a, ea);
		if (ed >= 0) chk("discarded", n_dis - d, ed);
		chk("watchdog cut", n_wd - w, ew);
	endtask : rx_case

	task automatic test_rx;
		rx_case(8'h00, 64, 0, 1, 0, 0, 0, 0);
		rx_case(8'h01, 64, 0, 1, 0, 1, 0, 0);
		rx_case(8'h01, 64, 0, 0, 0, 0, 1, 0);
		rx_case(8'h03, 64, 0, 0, 0, 1, 0, 0);
		rx_case(8'h09, 64, 0, 0, 1, 1, 0, 0);
		rx_case(8'h01, 63, 0, 1, 0, 0, 1, 0);
		rx_case(8'h05, 63, 0, 1, 0, 1, 0, 0);
		rx_case(8'h11, 64, 1, 1, 0, 0, 1, 0);
		rx_case(8'h01, 64, 1, 1, 0, 1, 0, 0);
		rx_case(8'h21, 1523, 0, 1, 0, 0, 1, 0);
		rx_case(8'h21, 1522, 0, 1, 0, 1, 0, 0);
		rx_case(8'h01, 2048, 0, 1, 0, 1, 0, 0);
		rx_case(8'h01, 2049, 0, 1, 0, -1, -1, 1);
		rx_case(8'h41, 2049, 0, 1, 0, 1, 0, 0);
		$display("rx test done");
	endtask : test_rx

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		test_reset();
		test_tx();
		test_irq();
		test_rx();
		wrap_up();
	end

	// about 15000 cycles expected; cut off well past that
	initial begin
		#(40 * 40000);
		err_count++;
		wrap_up();
	end
endmodule : tb_mtrcs_core

`default_nettype wire
